// >>> bench/plc_clock_control_bench.sv
// Self-checking bench of the clock control block
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
    failures = failures + 1; $display("[ERR] %0t got %h want %h", $time, g, e); end end
module plc_clock_control_bench;
    // Driven inputs
    reg         clk, rst, wr_s, rd_s, present, locked, rchg;
    reg  [7:0]  addr, wd, d;
    reg  [3:0]  rint, n, en;
    reg  [21:0] rfrac, f, ef;
    // Observed outputs
    wire [7:0]  rdata;
    wire [3:0]  pint;
    wire [21:0] pfrac;
    wire [1:0]  post;
    wire        osc_pd, osc_en, pll_pd, amode, pre, mclk_oe, mclk_osc, aux_en, aux_osc, valid;
    // Bench state
    integer     failures, n_compared, seed, cyc, i;
    plc_clock_control plc_clock_control_i (
        .sys_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .rx_stream_present_in(present), .rx_locked_in(locked), .rx_rate_change_in(rchg),
        .rx_int_in(rint), .rx_frac_in(rfrac), .osc_power_down_out(osc_pd),
        .osc_clock_enable_out(osc_en), .pll_power_down_out(pll_pd), .pll_auto_mode_out(amode),
        .pll_int_out(pint), .pll_frac_out(pfrac), .pre_divider_select_out(pre),
        .post_divider_select_out(post), .mclk_drive_oe_out(mclk_oe),
        .mclk_src_osc_out(mclk_osc), .aux_clock_output_en_out(aux_en),
        .aux_src_osc_out(aux_osc), .clocks_valid_out(valid));
    // 200 MHz clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    // One-cycle register write
    task wr(input [7:0] a, input [7:0] v); begin
        @(posedge clk);
        addr <= a;
        wd <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    end endtask
    // Read, masked compare in the following cycle
    task rd(input [7:0] a, input [7:0] m, input [7:0] e); begin
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        `CHK(rdata & m, e)
    end endtask
    // Let a write reach the control outputs
    task look; begin
        @(posedge clk);
        @(negedge clk);
    end endtask
    task tend(input string s);
        $display("test %s done", s);
    endtask
    task finish_test; begin
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end endtask
    // Hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            finish_test;
        end
    end
    initial begin
        seed = 32'h7ad885c5;
        failures = 0;
        n_compared = 0;
        cyc = 0;
        {rst, wr_s, rd_s, present, locked, rchg} = 6'b100010;
        {addr, wd, rint, rfrac} = 42'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset values
        @(negedge clk);
        `CHK({osc_pd, pll_pd, pint, pfrac}, {2'b11, 4'h7, 22'h36fd21})
        rd(8'h03, 8'hff, 8'h21);
        rd(8'h04, 8'hff, 8'hfd);
        rd(8'h05, 8'h3f, 8'h36);
        rd(8'h06, 8'h0f, 8'h07);
        rd(8'h1e, 8'h09, 8'h09);
        rd(8'h55, 8'hff, 8'h00);
        tend("reset");
        // Power-down bits, oscillator kept up while the pll runs
        for (i = 0; i < 8; i = i + 1) begin
            d = $random(seed);
            d[3] = d[3] & d[0];
            wr(8'h1e, d);
            look;
            `CHK({osc_pd, pll_pd, osc_en}, {d[3], d[0], ~d[3]})
        end
        tend("power");
        // Multiplier registers with integer in the usable range
        for (i = 0; i < 6; i = i + 1) begin
            f = $random(seed);
            n = 4'(5 + $unsigned($random(seed)) % 9);
            wr(8'h03, f[7:0]);
            wr(8'h04, f[15:8]);
            wr(8'h05, {2'b00, f[21:16]});
            wr(8'h06, {3'b000, i[0], n});
            look;
            `CHK({pint, pfrac, pre}, {n, f, i[0]})
            rd(8'h05, 8'h3f, {2'b00, f[21:16]});
            rd(8'h06, 8'h0f, {4'h0, n});
        end
        tend("ratio");
        // Output routing, oscillator up then down
        wr(8'h1e, 8'h00);
        for (i = 0; i < 16; i = i + 1) begin
            wr(8'h20, i[7:0]);
            look;
            `CHK({aux_osc, aux_en, mclk_osc, mclk_oe}, {i[3] & i[2], i[2], i[1] & i[0], i[0]})
        end
        rd(8'h20, 8'h0f, 8'h0f);
        wr(8'h1e, 8'h09);
        look;
        `CHK({aux_osc, mclk_osc}, 2'b00)
        tend("routing");
        // Automatic mode: default ratio, forced divider, tracking, hold, relock
        wr(8'h1e, 8'h00);
        wr(8'h06, 8'h08);
        wr(8'h03, 8'hba);
        wr(8'h04, 8'h49);
        wr(8'h05, 8'h0c);
        wr(8'h1f, 8'h01);
        look;
        `CHK({amode, pint, pfrac}, {1'b1, 4'h8, 22'h0c49ba})
        wr(8'h07, 8'h00);
        look;
        `CHK(post, 2'h2)
        en = $random(seed);
        ef = $random(seed);
        @(posedge clk);
        present <= 1'b1;
        rint <= en;
        rfrac <= ef;
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK({pint, pfrac}, {en, ef})
        @(posedge clk);
        present <= 1'b0;
        @(posedge clk);
        rint <= ~en;
        rfrac <= ~ef;
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK({pint, pfrac}, {en, ef})
        @(posedge clk);
        rchg <= 1'b1;
        @(posedge clk);
        rchg <= 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        `CHK(valid, 1'b0)
        repeat (15) @(posedge clk);
        @(negedge clk);
        `CHK(valid, 1'b1)
        rd(8'h21, 8'h03, 8'h03);
        rd(8'h07, 8'h03, 8'h00);
        wr(8'h1f, 8'h00);
        look;
        `CHK({amode, post, pint, pfrac}, {1'b0, 2'h0, 4'h8, 22'h0c49ba})
        tend("auto");
        finish_test;
    end
endmodule // plc_clock_control_bench

// >>> bench/plc_clock_control_sva.sv
// Port checker of the clock control block
`timescale 1ns/10ps
module plc_clock_control_sva (
    // Clock and reset
    input wire        sys_clk_in,
    input wire        sys_rst_in,
    // Register port and receiver side
    input wire [7:0]  reg_addr_in,
    input wire [7:0]  reg_wdata_in,
    input wire        reg_wr_in,
    input wire        rx_stream_present_in,
    input wire        rx_locked_in,
    input wire        rx_rate_change_in,
    // Watched outputs
    input wire        osc_power_down_out,
    input wire        osc_clock_enable_out,
    input wire        pll_power_down_out,
    input wire        pll_auto_mode_out,
    input wire [3:0]  pll_int_out,
    input wire [21:0] pll_frac_out,
    input wire [1:0]  post_divider_select_out,
    input wire        mclk_src_osc_out,
    input wire        aux_src_osc_out,
    input wire        clocks_valid_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Consecutive locked cycles with no rate change
    reg  [4:0] lock_cnt_reg;
    // Write to the power-down register
    wire       wr_pd;
    assign wr_pd = reg_wr_in && (reg_addr_in == 8'h1e);
    // Saturating lock counter, cleared by loss of lock or a rate change
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            lock_cnt_reg <= 5'h00;
        else if (!rx_locked_in || rx_rate_change_in)
            lock_cnt_reg <= 5'h00;
        else if (lock_cnt_reg != 5'h1f)
            lock_cnt_reg <= lock_cnt_reg + 5'h01;
    end
    a_osc_pd_write: assert property (wr_pd |-> ##2 osc_power_down_out == $past(reg_wdata_in[3], 2))
        else $error("oscillator power-down bit not applied");
    a_pll_pd_write: assert property (wr_pd |-> ##2 pll_power_down_out == $past(reg_wdata_in[0], 2))
        else $error("pll power-down bit not applied");
    a_osc_no_clock: assert property (osc_power_down_out && $past(osc_power_down_out) |-> !osc_clock_enable_out)
        else $error("oscillator clock runs while powered down");
    a_osc_route_gate: assert property (osc_power_down_out && $past(osc_power_down_out) |-> !(mclk_src_osc_out || aux_src_osc_out))
        else $error("oscillator routed while powered down");
    a_auto_enter: assert property (reg_wr_in && reg_addr_in == 8'h1f |-> ##2 pll_auto_mode_out == $past(reg_wdata_in[0], 2))
        else $error("automatic mode does not follow receiver enable");
    a_auto_post_div: assert property (pll_auto_mode_out && $past(pll_auto_mode_out) |-> post_divider_select_out == 2'h2)
        else $error("post divider not forced in automatic mode");
    a_auto_hold: assert property (pll_auto_mode_out && $past(pll_auto_mode_out, 2) && !rx_stream_present_in && !$past(rx_stream_present_in) && !$past(rx_stream_present_in, 2) |-> $stable(pll_frac_out) && $stable(pll_int_out))
        else $error("multiplier moved with no stream");
    a_rate_invalid: assert property (rx_rate_change_in && pll_auto_mode_out |-> ##[1:2] !clocks_valid_out)
        else $error("clocks still valid after rate change");
    a_lock_valid: assert property (lock_cnt_reg == 5'h17 |-> clocks_valid_out)
        else $error("clocks not valid after long lock");
    a_manual_int: assert property (reg_wr_in && reg_addr_in == 8'h06 ##2 !pll_auto_mode_out |-> pll_int_out == $past(reg_wdata_in[3:0], 2))
        else $error("integer multiplier not applied");
    // Main scenarios reached
    c_pd_write: cover property (wr_pd);
    c_rate_change: cover property (rx_rate_change_in && pll_auto_mode_out);
    c_relock: cover property (lock_cnt_reg == 5'h17);
endmodule // plc_clock_control_sva

bind plc_clock_control plc_clock_control_sva plc_clock_control_sva_i (.*);

// >>> verilog/plc_clock_control.v
// Oscillator, PLL power and ratio control with clock output routing
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module plc_clock_control (
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        sys_rst_in,
    // Register port
    input  wire [7:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    // Receiver recovery interface
    input  wire        rx_stream_present_in,
    input  wire        rx_locked_in,
    input  wire        rx_rate_change_in,
    input  wire [3:0]  rx_int_in,
    input  wire [21:0] rx_frac_in,
    // Oscillator and PLL control
    output reg         osc_power_down_out,
    output reg         osc_clock_enable_out,
    output reg         pll_power_down_out,
    output reg         pll_auto_mode_out,
    output reg  [3:0]  pll_int_out,
    output reg  [21:0] pll_frac_out,
    output reg         pre_divider_select_out,
    output reg  [1:0]  post_divider_select_out,
    // Clock output routing
    output reg         mclk_drive_oe_out,
    output reg         mclk_src_osc_out,
    output reg         aux_clock_output_en_out,
    output reg         aux_src_osc_out,
    output reg         clocks_valid_out
);
`include "plc_defines.vh"

    // Software held bits
    reg        osc_pd_reg;          // Oscillator power down
    reg        pll_pd_reg;          // PLL power down
    reg        pre_div_reg;         // Pre-scale select
    reg  [1:0] post_div_reg;        // Post-scale select as written
    reg        rx_enable_reg;       // Receiver enable, chooses automatic mode
    reg  [3:0] route_reg;           // Master and aux routing bits
    // Automatic mode tracked ratio
    reg  [3:0]  auto_int_reg;       // Integer held in automatic mode
    reg  [21:0] auto_frac_reg;      // Fraction held in automatic mode
    reg         invalid_reg;        // Clocks invalid after rate change
    reg  [7:0]  lock_cnt_reg;       // Lock settle counter
    // Bank interface
    wire [21:0] user_frac;          // Programmed fraction
    wire [3:0]  user_int;           // Programmed integer
    wire        bank_wr;            // Bank write strobe
    wire        bank_hit;           // Address maps to bank

    // Decide whether address is one of the four multiplier bytes
    function is_bank;
        input [7:0] addr;
        begin
            is_bank = (addr >= `PLC_ADDR_FRAC_LOW) && (addr <= `PLC_ADDR_INT_RATIO);
        end
    endfunction

    // Bank index from register address
    function [1:0] bank_idx;
        input [7:0] addr;
        reg   [7:0] diff;
        begin
            diff     = addr - `PLC_ADDR_FRAC_LOW;
            bank_idx = diff[1:0];
        end
    endfunction

    assign bank_hit = is_bank(reg_addr_in);
    assign bank_wr  = reg_wr_in & bank_hit;

    // Multiplier storage
    plc_reg_bank u_bank (
        .sys_clk_in  (sys_clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (bank_wr),
        .wr_idx_in   (bank_idx(reg_addr_in)),
        .wr_data_in  (reg_wdata_in),
        .rd_idx_in   (bank_idx(reg_addr_in)),
        .rd_data_out (),
        .frac_out    (user_frac),
        .int_out     (user_int)
    );

    // Register writes take effect on the next edge
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            osc_pd_reg    <= `PLC_RST_OSC_PD;
            pll_pd_reg    <= `PLC_RST_PLL_PD;
            pre_div_reg   <= `PLC_RST_PRE_DIV;
            post_div_reg  <= `PLC_RST_POST_DIV;
            rx_enable_reg <= 1'b0;
            route_reg     <= 4'h0;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `PLC_ADDR_POWER_DOWN: begin
                    osc_pd_reg <= reg_wdata_in[`PLC_BIT_OSC_PD];
                    pll_pd_reg <= reg_wdata_in[`PLC_BIT_PLL_PD];
                end
                `PLC_ADDR_INT_RATIO: begin
                    pre_div_reg <= reg_wdata_in[`PLC_BIT_PRE_DIV];
                end
                `PLC_ADDR_POST_DIV: begin
                    post_div_reg <= reg_wdata_in[1:0];
                end
                `PLC_ADDR_RX_CTRL: begin
                    rx_enable_reg <= reg_wdata_in[`PLC_BIT_RX_ENABLE];
                end
                `PLC_ADDR_CLK_ROUTE: begin
                    route_reg <= reg_wdata_in[3:0];
                end
                default: begin
                    route_reg <= route_reg;
                end
            endcase
        end
    end

    // Automatic mode ratio tracking, frozen when the stream stops
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            auto_int_reg  <= `PLC_AUTO_DEF_INT;
            auto_frac_reg <= `PLC_AUTO_DEF_FRAC;
        end else if (rx_enable_reg && rx_stream_present_in) begin
            auto_int_reg  <= rx_int_in;
            auto_frac_reg <= rx_frac_in;
        end else begin
            auto_int_reg  <= auto_int_reg;
            auto_frac_reg <= auto_frac_reg;
        end
    end

    // Invalid flag: set wins over the lock that clears it
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            invalid_reg  <= 1'b0;
            lock_cnt_reg <= 8'h00;
        end else if (rx_enable_reg && rx_rate_change_in) begin
            invalid_reg  <= 1'b1;
            lock_cnt_reg <= 8'h00;
        end else if (!rx_enable_reg) begin
            invalid_reg  <= 1'b0;
            lock_cnt_reg <= 8'h00;
        end else if (invalid_reg && rx_locked_in) begin
            // Lock must stand for the settle time before clearing
            if (lock_cnt_reg >= (`PLC_LOCK_WAIT_CYC - 1)) begin
                invalid_reg  <= 1'b0;
                lock_cnt_reg <= 8'h00;
            end else begin
                lock_cnt_reg <= lock_cnt_reg + 8'h01;
            end
        end else begin
            lock_cnt_reg <= 8'h00;
        end
    end

    // Registered outputs to oscillator, PLL and pin logic
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            osc_power_down_out      <= 1'b1;
            osc_clock_enable_out    <= 1'b0;
            pll_power_down_out      <= 1'b1;
            pll_auto_mode_out       <= 1'b0;
            pll_int_out             <= 4'h7;
            pll_frac_out            <= 22'h36fd21;
            pre_divider_select_out  <= 1'b0;
            post_divider_select_out <= 2'h2;
            mclk_drive_oe_out       <= 1'b0;
            mclk_src_osc_out        <= 1'b0;
            aux_clock_output_en_out <= 1'b0;
            aux_src_osc_out         <= 1'b0;
            clocks_valid_out        <= 1'b0;
        end else begin
            osc_power_down_out   <= osc_pd_reg;
            osc_clock_enable_out <= ~osc_pd_reg;
            pll_power_down_out   <= pll_pd_reg;
            pll_auto_mode_out    <= rx_enable_reg;
            pre_divider_select_out <= pre_div_reg;
            if (rx_enable_reg) begin
                // Receiver drives ratio, post divider forced to PLC_AUTO_POST_DIV
                pll_int_out             <= auto_int_reg;
                pll_frac_out            <= auto_frac_reg;
                post_divider_select_out <= `PLC_AUTO_POST_DIV;
            end else begin
                // User programmed settings only
                pll_int_out             <= user_int;
                pll_frac_out            <= user_frac;
                post_divider_select_out <= post_div_reg;
            end
            // Oscillator source only when it is powered
            mclk_drive_oe_out       <= route_reg[`PLC_BIT_MCLK_OUT];
            mclk_src_osc_out        <= route_reg[`PLC_BIT_MCLK_OUT] &
                                       route_reg[`PLC_BIT_MCLK_OSC] & ~osc_pd_reg;
            aux_clock_output_en_out <= route_reg[`PLC_BIT_AUX_EN];
            aux_src_osc_out         <= route_reg[`PLC_BIT_AUX_EN] &
                                       route_reg[`PLC_BIT_AUX_OSC] & ~osc_pd_reg;
            clocks_valid_out        <= ~invalid_reg;
        end
    end

    // Read data register, stands only in the cycle after the read strobe
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            // Multiplier bytes mirror the bank; pre-scale bit is not read back
            case (reg_addr_in)
                `PLC_ADDR_FRAC_LOW:   reg_rdata_out <= user_frac[7:0];
                `PLC_ADDR_FRAC_MID:   reg_rdata_out <= user_frac[15:8];
                `PLC_ADDR_FRAC_HIGH:  reg_rdata_out <= {2'b00, user_frac[21:16]};
                `PLC_ADDR_INT_RATIO:  reg_rdata_out <= {4'h0, user_int};
                `PLC_ADDR_POWER_DOWN: reg_rdata_out <= {4'h0, osc_pd_reg, 2'b00, pll_pd_reg};
                `PLC_ADDR_POST_DIV:   reg_rdata_out <= {6'h00, post_div_reg};
                `PLC_ADDR_RX_CTRL:    reg_rdata_out <= {7'h00, rx_enable_reg};
                `PLC_ADDR_CLK_ROUTE:  reg_rdata_out <= {4'h0, route_reg};
                `PLC_ADDR_STATUS:     reg_rdata_out <= {6'h00, rx_enable_reg, ~invalid_reg};
                default:              reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end
endmodule // plc_clock_control

// >>> verilog/plc_defines.vh
// Register map, field positions, reset values and timing for the clock control block
`ifndef PLC_DEFINES_VH
`define PLC_DEFINES_VH

// Register offsets
`define PLC_ADDR_FRAC_LOW      8'h03
`define PLC_ADDR_FRAC_MID      8'h04
`define PLC_ADDR_FRAC_HIGH     8'h05
`define PLC_ADDR_INT_RATIO     8'h06
`define PLC_ADDR_POST_DIV      8'h07
`define PLC_ADDR_RX_CTRL       8'h1f
`define PLC_ADDR_CLK_ROUTE     8'h20
`define PLC_ADDR_STATUS        8'h21
`define PLC_ADDR_POWER_DOWN    8'h1e

// Reset values
`define PLC_RST_FRAC_LOW       8'h21
`define PLC_RST_FRAC_MID       8'hfd
`define PLC_RST_FRAC_HIGH      6'h36
`define PLC_RST_INT_RATIO      4'h7
`define PLC_RST_PRE_DIV        1'b0
`define PLC_RST_POST_DIV       2'h2
`define PLC_RST_OSC_PD         1'b1
`define PLC_RST_PLL_PD         1'b1

// Automatic mode defaults: ratio for about 24MHz out of a 12MHz reference after post divide
`define PLC_AUTO_DEF_INT       4'h8
`define PLC_AUTO_DEF_FRAC      22'h0c49ba
`define PLC_AUTO_POST_DIV      2'h2

// Field positions
`define PLC_BIT_OSC_PD         3
`define PLC_BIT_PLL_PD         0
`define PLC_BIT_PRE_DIV        4
`define PLC_BIT_RX_ENABLE      0
`define PLC_BIT_MCLK_OUT       0
`define PLC_BIT_MCLK_OSC       1
`define PLC_BIT_AUX_EN         2
`define PLC_BIT_AUX_OSC        3

// Fractional ratio width
`define PLC_FRAC_W             22

// Lock wait after a rate change: time in ns and derived cycles at 5 ns
`define PLC_CLK_PERIOD_NS      5
`define PLC_LOCK_WAIT_NS       100
`define PLC_LOCK_WAIT_CYC      ((`PLC_LOCK_WAIT_NS + `PLC_CLK_PERIOD_NS - 1) / `PLC_CLK_PERIOD_NS)

`endif

// >>> verilog/plc_reg_bank.v
// Small memory of the four multiplier bytes with registered read data
`timescale 1ns/10ps
module plc_reg_bank (
    // Clock and reset
    input  wire       sys_clk_in,
    input  wire       sys_rst_in,
    // Write port
    input  wire       wr_en_in,
    input  wire [1:0] wr_idx_in,
    input  wire [7:0] wr_data_in,
    // Read port
    input  wire [1:0] rd_idx_in,
    output reg  [7:0] rd_data_out,
    // Whole ratio
    output wire [21:0] frac_out,
    output wire [3:0]  int_out
);
`include "plc_defines.vh"

    reg [7:0] mem_reg [0:3];  // Bytes: frac low, mid, high, integer

    assign frac_out = {mem_reg[2][5:0], mem_reg[1], mem_reg[0]};
    assign int_out  = mem_reg[3][3:0];

    // Write path, reset loads documented patterns
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mem_reg[0] <= `PLC_RST_FRAC_LOW;
            mem_reg[1] <= `PLC_RST_FRAC_MID;
            mem_reg[2] <= {2'b00, `PLC_RST_FRAC_HIGH};
            mem_reg[3] <= {4'h0, `PLC_RST_INT_RATIO};
        end else if (wr_en_in) begin
            // Unused upper bits of high and integer bytes stay zero
            case (wr_idx_in)
                2'd2:    mem_reg[2] <= {2'b00, wr_data_in[5:0]};
                2'd3:    mem_reg[3] <= {4'h0, wr_data_in[3:0]};
                default: mem_reg[wr_idx_in] <= wr_data_in;
            endcase
        end
    end

    // Registered read
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= mem_reg[rd_idx_in];
        end
    end
endmodule // plc_reg_bank
